// >>> hdl/i2cbc_pkg.sv
// Constants, types and behaviour list for the I2C bus control and status block
// Behaviour
// - Control write with start bit 1, master, transmitter, no pending service: issue start.
// - Same control write with start bit 0 issues a stop condition instead.
// - Writing 1 to pending bit releases service request; writing 0 does nothing.
// - Mode field 00 selects port mode, 10 selects I2C mode; 01, 11 reserved.
// - Soft reset in I2C mode initialises all control and status except mode.
// - Soft reset monitor bit 0 reads 0 during soft reset, otherwise 1.
// - Control and status B reset to 0001 0000.
// - Pending bit reads 0 while service is requested, 1 once released.
// - Arbitration lost bit reads 1 after arbitration is lost.
// - Address matched reads 1 on own address or general call; general call flag separate.
// - Last received bit holds most recent data line bit.
// - Master select 1 makes a master, 0 a slave.
// - Transmit select 1 makes a transmitter, 0 a receiver.
// - Hardware clears master select on stop condition or lost arbitration.
package i2cbc_pkg;
	localparam logic [11:0] SOFT_RESET_STATUS_IDX = 12'hF90;
	localparam logic [11:0] BUS_CONTROL_IDX = 12'hF93;
	localparam logic [11:0] BUS_STATUS_IDX = 12'hF93;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 12;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
	localparam int CTL_MASTER_BIT = 7;
	localparam int CTL_TRANSMIT_BIT = 6;
	localparam int CTL_START_BIT = 5;
	localparam int CTL_PIN_BIT = 4;
	localparam int CTL_MODE_HI = 3;
	localparam int CTL_MODE_LO = 2;
	localparam int CTL_KEY_HI = 1;
	localparam int CTL_KEY_LO = 0;
	localparam int SRA_MON_BIT = 0;
	localparam logic [1:0] MODE_PORT = 2'h0;
	localparam logic [1:0] MODE_I2C = 2'h2;
	localparam logic [1:0] KEY_FIRST = 2'h2;
	localparam logic [1:0] KEY_SECOND = 2'h1;
	localparam logic [7:0] BUS_STATUS_RESET = 8'h10;
	localparam logic [7:0] BUS_CONTROL_RESET = 8'h10;
	localparam logic [7:0] SOFT_RESET_STATUS_RESET = 8'h01;
	localparam int SRST_CYCLES = 4;
	typedef struct packed {
		logic master_sel;
		logic transmit_sel;
		logic busy;
		logic pin_n;
		logic arb_lost;
		logic addr_match;
		logic gen_call;
		logic last_bit;
	} i2cbc_status_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [IDX_W-1:0] idx;
	} i2cbc_aphase_t;
	typedef enum logic [1:0] {
		I2CBC_KEY_IDLE = 2'b00,
		I2CBC_KEY_ARMED = 2'b01,
		I2CBC_KEY_RUN = 2'b10
	} i2cbc_key_state_t;
endpackage : i2cbc_pkg

// >>> hdl/i2cbc_cond_detect.sv
// Start, stop and received bit detection on the shared pins
`timescale 1ns/100ps
module i2cbc_cond_detect (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic sda_in,
	input wire logic scl_in,
	output logic start_p,
	output logic stop_p,
	output logic busy,
	output logic last_bit
);
	logic sda_q;
	logic scl_q;
	logic start_q;
	logic stop_q;
	logic busy_q;
	logic last_q;
	wire start_w = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_w = scl_in & scl_q & ~sda_q & sda_in;
	wire scl_rise = scl_in & ~scl_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			sda_q <= 1'b1;
			scl_q <= 1'b1;
		end else begin
			sda_q <= sda_in;
			scl_q <= scl_in;
		end
	end
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			start_q <= 1'b0;
			stop_q <= 1'b0;
			busy_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			start_q <= start_w;
			stop_q <= stop_w;
			busy_q <= start_w | (busy_q & ~stop_w);
			last_q <= scl_rise ? sda_in : last_q;
		end
	end
	assign start_p = start_q;
	assign stop_p = stop_q;
	assign busy = busy_q;
	assign last_bit = last_q;
endmodule : i2cbc_cond_detect

// >>> hdl/i2cbc_soft_reset.sv
// Two-write key sequencer and soft reset timer
`timescale 1ns/100ps
module i2cbc_soft_reset #(
	parameter int RUN_CYCLES = i2cbc_pkg::SRST_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic key_wr,
	input wire logic [1:0] key,
	output logic active
);
	localparam int CNT_W = $clog2(RUN_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RUN_CYCLES - 1);
	i2cbc_pkg::i2cbc_key_state_t state_q;
	i2cbc_pkg::i2cbc_key_state_t state_d;
	logic [CNT_W-1:0] cnt_q;
	wire is_first = key == i2cbc_pkg::KEY_FIRST;
	wire is_second = key == i2cbc_pkg::KEY_SECOND;
	wire run_done = cnt_q == CNT_LAST;
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			i2cbc_pkg::I2CBC_KEY_IDLE: begin
				if (key_wr && enable && is_first) begin
					state_d = i2cbc_pkg::I2CBC_KEY_ARMED;
				end
			end
			i2cbc_pkg::I2CBC_KEY_ARMED: begin
				if (!enable) begin
					state_d = i2cbc_pkg::I2CBC_KEY_IDLE;
				end else if (key_wr) begin
					state_d = is_second ? i2cbc_pkg::I2CBC_KEY_RUN :
						(is_first ? i2cbc_pkg::I2CBC_KEY_ARMED : i2cbc_pkg::I2CBC_KEY_IDLE);
				end
			end
			i2cbc_pkg::I2CBC_KEY_RUN: begin
				if (run_done) begin
					state_d = i2cbc_pkg::I2CBC_KEY_IDLE;
				end
			end
			default: begin
				state_d = i2cbc_pkg::I2CBC_KEY_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= i2cbc_pkg::I2CBC_KEY_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= (state_q == i2cbc_pkg::I2CBC_KEY_RUN) ? cnt_q + CNT_W'(1) : '0;
		end
	end
	assign active = state_q == i2cbc_pkg::I2CBC_KEY_RUN;
endmodule : i2cbc_soft_reset

// >>> hdl/i2cbc_top.sv
// AHB-Lite register slave for I2C bus control, status and soft reset
`timescale 1ns/100ps
module i2cbc_top #(
	parameter int SRST_RUN_CYCLES = i2cbc_pkg::SRST_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic sda_in,
	input wire logic scl_in,
	input wire logic ev_service_req,
	input wire logic ev_arb_lost,
	input wire logic ev_addr_match,
	input wire logic ev_general_call,
	output logic gen_start,
	output logic gen_stop,
	output logic master_mode,
	output logic transmit_mode,
	output logic i2c_mode,
	output logic port_mode,
	output logic bus_busy,
	output logic sub_init
);

	// Address decode shared by read and write paths
	function automatic logic reg_hit(input logic [31:0] addr, input logic [i2cbc_pkg::IDX_W-1:0] idx);
		logic [31:0] byte_addr;
		byte_addr = 32'(idx) << i2cbc_pkg::IDX_LSB;
		reg_hit = addr == byte_addr;
	endfunction : reg_hit

	// Bus state
	i2cbc_pkg::i2cbc_aphase_t aph_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	logic hresp_q;

	// Register state
	i2cbc_pkg::i2cbc_status_t stat_q;
	logic [1:0] mode_q;

	// Output flops
	logic gen_start_q;
	logic gen_stop_q;
	logic master_mode_q;
	logic transmit_mode_q;
	logic i2c_mode_q;
	logic port_mode_q;
	logic bus_busy_q;
	logic sub_init_q;

	// Submodule outputs
	logic det_start;
	logic det_stop;
	logic det_busy;
	logic det_last;
	logic srst_active;

	// Address phase acceptance
	wire aph_take = hsel & hready & (htrans == i2cbc_pkg::HTRANS_NONSEQ);
	wire aph_word = hsize == i2cbc_pkg::HSIZE_WORD;
	wire hit_sra = reg_hit(haddr, i2cbc_pkg::SOFT_RESET_STATUS_IDX);
	wire hit_bus = reg_hit(haddr, i2cbc_pkg::BUS_CONTROL_IDX);
	wire [i2cbc_pkg::IDX_W-1:0] aph_idx = hit_sra ? i2cbc_pkg::SOFT_RESET_STATUS_IDX :
		i2cbc_pkg::BUS_CONTROL_IDX;
	wire aph_mapped = (hit_sra | hit_bus) & aph_word;

	// Read selection
	// monitor low in reset
	wire [7:0] sra_value = {7'h00, ~srst_active};
	wire [7:0] bus_read = stat_q;
	wire rd_sra = aph_take & ~hwrite & hit_sra & aph_word;
	wire rd_bus = aph_take & ~hwrite & reg_hit(haddr, i2cbc_pkg::BUS_STATUS_IDX) & aph_word;
	wire [7:0] rd_byte = rd_sra ? sra_value : (rd_bus ? bus_read : 8'h00);

	// Data phase write strobes
	// write lands in control bits
	wire wr_ctl = aph_q.valid & aph_q.write & (aph_q.idx == i2cbc_pkg::BUS_CONTROL_IDX);
	wire [7:0] wbyte = hwdata[7:0];
	wire w_master = wbyte[i2cbc_pkg::CTL_MASTER_BIT];
	wire w_transmit = wbyte[i2cbc_pkg::CTL_TRANSMIT_BIT];
	wire w_start = wbyte[i2cbc_pkg::CTL_START_BIT];
	wire w_pin = wbyte[i2cbc_pkg::CTL_PIN_BIT];
	wire [1:0] w_mode = wbyte[i2cbc_pkg::CTL_MODE_HI:i2cbc_pkg::CTL_MODE_LO];
	wire [1:0] w_key = wbyte[i2cbc_pkg::CTL_KEY_HI:i2cbc_pkg::CTL_KEY_LO];

	// Mode decode
	// reserved codes are not taken
	wire w_mode_ok = (w_mode == i2cbc_pkg::MODE_PORT) | (w_mode == i2cbc_pkg::MODE_I2C);
	wire in_i2c = mode_q == i2cbc_pkg::MODE_I2C;
	wire in_port = mode_q == i2cbc_pkg::MODE_PORT;

	// Start and stop request qualification
	// start when master transmitter released
	// stop when start bit is 0
	wire cond_gen = wr_ctl & in_i2c & ~srst_active & w_master & w_transmit & stat_q.pin_n;
	wire start_req = cond_gen & w_start;
	wire stop_req = cond_gen & ~w_start;

	// Hardware clear events
	// stop or lost arbitration ends master
	wire hw_drop = det_stop | ev_arb_lost;
	wire ctl_wr_ok = wr_ctl & ~srst_active;

	// Next status values
	logic master_d;
	logic transmit_d;
	logic pin_n_d;
	logic arb_lost_d;
	logic addr_match_d;
	logic gen_call_d;

	assign master_d = hw_drop ? 1'b0 : (ctl_wr_ok ? w_master : stat_q.master_sel);
	assign transmit_d = hw_drop ? 1'b0 : (ctl_wr_ok ? w_transmit : stat_q.transmit_sel);
	// only a 1 releases the request
	assign pin_n_d = ev_service_req ? 1'b0 : ((ctl_wr_ok & w_pin) ? 1'b1 : stat_q.pin_n);
	assign arb_lost_d = ev_arb_lost ? 1'b1 : (det_start ? 1'b0 : stat_q.arb_lost);
	assign addr_match_d = ev_addr_match ? 1'b1 : ((det_start | det_stop) ? 1'b0 : stat_q.addr_match);
	assign gen_call_d = (ev_addr_match & ev_general_call) ? 1'b1 :
		((det_start | det_stop) ? 1'b0 : stat_q.gen_call);

	// Key write for the soft reset sequencer
	wire key_wr = wr_ctl;

	// Condition detector
	i2cbc_cond_detect u_detect (
		.clk(clk),
		.rst(rst),
		.clear(srst_active),
		.sda_in(sda_in),
		.scl_in(scl_in),
		.start_p(det_start),
		.stop_p(det_stop),
		.busy(det_busy),
		.last_bit(det_last)
	);

	// Soft reset sequencer
	// two-write key, I2C mode only
	i2cbc_soft_reset #(
		.RUN_CYCLES(SRST_RUN_CYCLES)
	) u_srst (
		.clk(clk),
		.rst(rst),
		.enable(in_i2c),
		.key_wr(key_wr),
		.key(w_key),
		.active(srst_active)
	);

	// Address phase capture
	always_ff @(posedge clk) begin
		if (rst) begin
			aph_q <= '0;
		end else if (hready) begin
			aph_q.valid <= aph_take & aph_mapped;
			aph_q.write <= hwrite;
			aph_q.idx <= aph_idx;
		end
	end

	// Read data and response
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata_q <= 32'h00000000;
		end else if (hready) begin
			hrdata_q <= {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hreadyout_q <= 1'b1;
			hresp_q <= i2cbc_pkg::HRESP_OKAY;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q <= i2cbc_pkg::HRESP_OKAY;
		end
	end

	// Status register
	// reset value 0001 0000
	always_ff @(posedge clk) begin
		if (rst || srst_active) begin
			stat_q <= i2cbc_pkg::BUS_STATUS_RESET;
		end else begin
			stat_q.master_sel <= master_d;
			stat_q.transmit_sel <= transmit_d;
			stat_q.busy <= det_busy;
			stat_q.pin_n <= pin_n_d;
			stat_q.arb_lost <= arb_lost_d;
			stat_q.addr_match <= addr_match_d;
			stat_q.gen_call <= gen_call_d;
			stat_q.last_bit <= det_last;
		end
	end

	// Mode field survives soft reset
	// mode kept through soft reset
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= i2cbc_pkg::BUS_CONTROL_RESET[i2cbc_pkg::CTL_MODE_HI:i2cbc_pkg::CTL_MODE_LO];
		end else if (wr_ctl && w_mode_ok) begin
			mode_q <= w_mode;
		end
	end

	// Start and stop pulses
	always_ff @(posedge clk) begin
		if (rst) begin
			gen_start_q <= 1'b0;
			gen_stop_q <= 1'b0;
		end else begin
			gen_start_q <= start_req;
			gen_stop_q <= stop_req;
		end
	end

	// Mode and role outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			master_mode_q <= 1'b0;
			transmit_mode_q <= 1'b0;
			bus_busy_q <= 1'b0;
		end else begin
			master_mode_q <= stat_q.master_sel;
			transmit_mode_q <= stat_q.transmit_sel;
			bus_busy_q <= stat_q.busy;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			i2c_mode_q <= 1'b0;
			port_mode_q <= 1'b1;
		end else begin
			i2c_mode_q <= in_i2c;
			port_mode_q <= in_port;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sub_init_q <= 1'b0;
		end else begin
			sub_init_q <= srst_active;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;
	assign gen_start = gen_start_q;
	assign gen_stop = gen_stop_q;
	assign master_mode = master_mode_q;
	assign transmit_mode = transmit_mode_q;
	assign i2c_mode = i2c_mode_q;
	assign port_mode = port_mode_q;
	assign bus_busy = bus_busy_q;
	assign sub_init = sub_init_q;

endmodule : i2cbc_top

// >>> tb/i2cbc_assertions.sv
// Checker for the I2C bus control and status block
`timescale 1ns/100ps
module i2cbc_assertions #(
	parameter int SRST_RUN_CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic ev_arb_lost,
	input wire logic gen_start,
	input wire logic gen_stop,
	input wire logic master_mode,
	input wire logic transmit_mode,
	input wire logic i2c_mode,
	input wire logic port_mode,
	input wire logic sub_init
);
	logic ap_q;
	logic [3:0] cnt_q;
	// Control write data phase and soft reset length
	always_ff @(posedge clk) begin
		ap_q <= !rst && hsel && hready && htrans == 2'h2 && hwrite && hsize == 3'h2 && haddr == 32'h3E4C;
		cnt_q <= (rst || !sub_init) ? 4'h0 : cnt_q + 4'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_start; gen_start |-> $past(ap_q && hwdata[7:5] == 3'h7); endproperty
	a_start: assert property (p_start) else $error("start pulse without start write");
	property p_stop; gen_stop |-> $past(ap_q && hwdata[7:5] == 3'h6); endproperty
	a_stop: assert property (p_stop) else $error("stop pulse without stop write");
	property p_excl; !(i2c_mode && port_mode); endproperty
	a_excl: assert property (p_excl) else $error("both modes active");
	property p_i2c; ap_q && hwdata[3:2] == 2'h2 |-> ##[1:2] i2c_mode; endproperty
	a_i2c: assert property (p_i2c) else $error("bus mode not entered");
	property p_port; ap_q && hwdata[3:2] == 2'h0 |-> ##[1:2] port_mode; endproperty
	a_port: assert property (p_port) else $error("port mode not entered");
	property p_key; $rose(sub_init) |-> $past(ap_q && hwdata[1:0] == 2'h1, 2); endproperty
	a_key: assert property (p_key) else $error("soft reset without second key");
	property p_len; $fell(sub_init) |-> cnt_q == SRST_RUN_CYCLES; endproperty
	a_len: assert property (p_len) else $error("soft reset length wrong");
	property p_clr; sub_init |-> !master_mode && !transmit_mode; endproperty
	a_clr: assert property (p_clr) else $error("role kept in soft reset");
	property p_arb; ev_arb_lost |-> ##[1:3] !master_mode; endproperty
	a_arb: assert property (p_arb) else $error("master kept after arbitration loss");
	property p_rdata; hrdata[31:8] == 24'h0; endproperty
	a_rdata: assert property (p_rdata) else $error("upper read data not zero");
endmodule : i2cbc_assertions
bind i2cbc_top i2cbc_assertions #(.SRST_RUN_CYCLES(SRST_RUN_CYCLES)) chk_u (.clk(clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .ev_arb_lost(ev_arb_lost), .gen_start(gen_start), .gen_stop(gen_stop),
	.master_mode(master_mode), .transmit_mode(transmit_mode), .i2c_mode(i2c_mode), .port_mode(port_mode),
	.sub_init(sub_init));

// >>> tb/i2cbc_bus_model.sv
// Far-side bus device driving the shared clock and data lines
`timescale 1ns/100ps
module i2cbc_bus_model (
	input wire logic clk,
	output logic sda,
	output logic scl
);
	initial begin
		sda = 1'b1;
		scl = 1'b1;
	end
	task step;
		repeat (4) @(posedge clk);
	endtask : step
	task send_start;
		sda <= 1'b0;
		step();
		scl <= 1'b0;
		step();
	endtask : send_start
	task send_bit(input logic b);
		sda <= b;
		step();
		scl <= 1'b1;
		step();
		scl <= 1'b0;
		step();
		sda <= 1'b1;
		step();
	endtask : send_bit
	task send_stop;
		sda <= 1'b0;
		step();
		scl <= 1'b1;
		step();
		sda <= 1'b1;
		step();
	endtask : send_stop
endmodule : i2cbc_bus_model

// >>> tb/i2cbc_top_tb.sv
// Testbench for the I2C bus control and status block
`timescale 1ns/100ps
module i2cbc_top_tb;
	localparam logic [31:0] A_SRA = 32'h3E40;
	localparam logic [31:0] A_CTL = 32'h3E4C;
	logic clk, rst, hsel, hwrite, ev_srv, ev_arb, ev_am, ev_gc, sda, scl;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, gen_start, gen_stop, master, transmit, i2c, port, busy, sub_init;
	int num_errors = 0;
	int compares = 0;
	i2cbc_top #(.SRST_RUN_CYCLES(4)) dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .sda_in(sda), .scl_in(scl), .ev_service_req(ev_srv),
		.ev_arb_lost(ev_arb), .ev_addr_match(ev_am), .ev_general_call(ev_gc), .gen_start(gen_start),
		.gen_stop(gen_stop), .master_mode(master), .transmit_mode(transmit), .i2c_mode(i2c), .port_mode(port),
		.bus_busy(busy), .sub_init(sub_init));
	i2cbc_bus_model bus_u (.clk(clk), .sda(sda), .scl(scl));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task stop_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", n, exp, seen);
		end
	endtask : check
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			stop_test();
		end
	endtask : wait_ready
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		wait_ready();
		@(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		@(posedge clk);
	endtask : xfer
	task wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task rdc(input string n, input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(n, rd, exp);
		check("resp", 32'(hresp), 32'h0);
	endtask : rdc
	task pulse(input logic s, input logic p);
		@(negedge clk);
		check("start", 32'(gen_start), 32'(s));
		check("stop", 32'(gen_stop), 32'(p));
		@(posedge clk);
	endtask : pulse
	task ev(input logic [3:0] e);
		{ev_srv, ev_arb, ev_am, ev_gc} <= e;
		@(posedge clk);
		{ev_srv, ev_arb, ev_am, ev_gc} <= 4'h0;
		repeat (3) @(posedge clk);
	endtask : ev
	initial begin
		{rst, hsel, hwrite, ev_srv, ev_arb, ev_am, ev_gc} = 7'h40;
		{haddr, hwdata, htrans, hsize} = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdc("status", A_CTL, 32'h10);
		rdc("monitor", A_SRA, 32'h01);
		rdc("unmapped", 32'h3E44, 32'h0);
		wr(A_SRA, 32'h0);
		rdc("monitor", A_SRA, 32'h01);
		wr(A_CTL, 32'h0C);
		repeat (2) @(posedge clk);
		check("port", 32'({port, i2c}), 32'h2);
		wr(A_CTL, 32'h08);
		repeat (2) @(posedge clk);
		check("i2c", 32'({port, i2c}), 32'h1);
		wr(A_CTL, 32'hF8);
		pulse(1'b1, 1'b0);
		rdc("status", A_CTL, 32'hD0);
		check("role", 32'({master, transmit}), 32'h3);
		wr(A_CTL, 32'hD8);
		pulse(1'b0, 1'b1);
		ev(4'h8);
		rdc("status", A_CTL, 32'hC0);
		wr(A_CTL, 32'hE8);
		pulse(1'b0, 1'b0);
		rdc("status", A_CTL, 32'hC0);
		wr(A_CTL, 32'hD8);
		pulse(1'b0, 1'b0);
		rdc("status", A_CTL, 32'hD0);
		ev(4'h4);
		rdc("status", A_CTL, 32'h18);
		bus_u.send_start();
		rdc("status", A_CTL, 32'h30);
		check("busy", 32'(busy), 32'h1);
		ev(4'h2);
		rdc("status", A_CTL, 32'h34);
		ev(4'h3);
		bus_u.send_bit(1'b1);
		rdc("status", A_CTL, 32'h37);
		wr(A_CTL, 32'hD8);
		bus_u.send_stop();
		rdc("status", A_CTL, 32'h10);
		check("busy", 32'(busy), 32'h0);
		wr(A_CTL, 32'hCA);
		wr(A_CTL, 32'h18);
		wr(A_CTL, 32'h19);
		rdc("monitor", A_SRA, 32'h01);
		ev(4'h4);
		wr(A_CTL, 32'hCA);
		wr(A_CTL, 32'h19);
		rdc("monitor", A_SRA, 32'h00);
		check("sub_init", 32'(sub_init), 32'h1);
		repeat (8) @(posedge clk);
		rdc("monitor", A_SRA, 32'h01);
		rdc("status", A_CTL, 32'h10);
		check("i2c", 32'(i2c), 32'h1);
		check("sub_init", 32'(sub_init), 32'h0);
		wr(A_CTL, 32'h04);
		repeat (2) @(posedge clk);
		check("i2c", 32'(i2c), 32'h1);
		// mode 00 returns to port mode
		wr(A_CTL, 32'h00);
		repeat (2) @(posedge clk);
		check("port", 32'(port), 32'h1);
		stop_test();
	end
endmodule : i2cbc_top_tb
